// *** core/ttc_pkg.sv ***
/* constants, register map and bus carriers of the three timer/counter unit.
   assumes one 200 MHz clock and an AXI4-Lite master with 32-bit data. */
package ttc_pkg;
    localparam logic [31:0] OFS_CTRL = 32'h00;
    localparam logic [31:0] OFS_TIMER_MODE_REG = 32'h04;
    localparam logic [31:0] OFS_T0 = 32'h08;
    localparam logic [31:0] OFS_T1 = 32'h0c;
    localparam logic [31:0] OFS_THIRD_TIMER_CONTROL_REG = 32'h10;
    localparam logic [31:0] OFS_THIRD_TIMER_MODE_REG = 32'h14;
    localparam logic [31:0] OFS_T2CNT = 32'h18;
    localparam logic [31:0] OFS_CAP = 32'h1c;
    localparam logic [31:0] OFS_SPEED = 32'h20;
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_TIMER_MODE_REG = 4'h1;
    localparam logic [3:0] IDX_T0 = 4'h2;
    localparam logic [3:0] IDX_T1 = 4'h3;
    localparam logic [3:0] IDX_THIRD_TIMER_CONTROL_REG = 4'h4;
    localparam logic [3:0] IDX_THIRD_TIMER_MODE_REG = 4'h5;
    localparam logic [3:0] IDX_T2CNT = 4'h6;
    localparam logic [3:0] IDX_CAP = 4'h7;
    localparam logic [3:0] IDX_SPEED = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hf;
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [3:0] DIV_LAST = 4'hb;
    localparam logic [1:0] FAST_PHASE = 2'h3;
    localparam logic [7:0] BYTE_TOP = 8'hff;
    localparam logic [12:0] M0_TOP = 13'h1fff;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int PIN_T0 = 0;
    localparam int PIN_T1 = 1;
    localparam int PIN_INT0 = 2;
    localparam int PIN_INT1 = 3;
    localparam int PIN_T2 = 4;
    localparam int PIN_CAPDIR = 5;

    typedef struct packed {
        logic second_timer_overflow;
        logic first_timer_overflow;
        logic second_timer_run;
        logic first_timer_run;
    } ttc_timer_control_reg_s;

    typedef struct packed {
        logic gate1;
        logic ct1;
        logic [1:0] mode1;
        logic gate0;
        logic ct0;
        logic [1:0] mode0;
    } ttc_timer_mode_reg_s;

    typedef struct packed {
        logic third_timer_overflow;
        logic external_event_flag;
        logic receive_baud_select;
        logic transmit_baud_select;
        logic external_event_enable;
        logic third_timer_run;
        logic third_source_select;
        logic capture_reload_select;
    } ttc_third_timer_control_reg_s;

    typedef struct packed {
        logic clear_after_capture;
        logic up_down_enable;
    } ttc_third_timer_mode_reg_s;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } ttc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ttc_axi_rsp_s;

    function automatic logic [3:0] ttc_decode(input logic [31:0] addr);
        case (addr)
            OFS_CTRL: ttc_decode = IDX_CTRL;
            OFS_TIMER_MODE_REG: ttc_decode = IDX_TIMER_MODE_REG;
            OFS_T0: ttc_decode = IDX_T0;
            OFS_T1: ttc_decode = IDX_T1;
            OFS_THIRD_TIMER_CONTROL_REG: ttc_decode = IDX_THIRD_TIMER_CONTROL_REG;
            OFS_THIRD_TIMER_MODE_REG: ttc_decode = IDX_THIRD_TIMER_MODE_REG;
            OFS_T2CNT: ttc_decode = IDX_T2CNT;
            OFS_CAP: ttc_decode = IDX_CAP;
            OFS_SPEED: ttc_decode = IDX_SPEED;
            default: ttc_decode = IDX_NONE;
        endcase
    endfunction : ttc_decode
endpackage : ttc_pkg

// *** core/ttc_top.sv ***
/* three timer/counters behind an AXI4-Lite register slave.
   assumes pins are asynchronous; software clears all flags. */
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ttc_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire ttc_pkg::ttc_axi_req_s axi_req,
    output ttc_pkg::ttc_axi_rsp_s axi_rsp,
    input wire logic first_count_pin,
    input wire logic second_count_pin,
    input wire logic third_count_pin,
    input wire logic [1:0] external_irq_pin_n,
    input wire logic capture_direction_pin,
    output logic first_timer_overflow,
    output logic second_timer_overflow,
    output logic third_timer_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // machine cycle enables
    logic [3:0] div_q;
    logic tick_slow, tick_fast;
    logic [2:0] speed_q, tk;
    always_ff @(posedge clock) begin
        if (!rst_n) div_q <= '0;
        else if (div_q == ttc_pkg::DIV_LAST) div_q <= '0;
        else div_q <= div_q + 4'h1;
    end
    assign tick_slow = (div_q == ttc_pkg::DIV_LAST);
    assign tick_fast = (div_q[1:0] == ttc_pkg::FAST_PHASE);
    assign tk = ({3{tick_fast}} & speed_q) | ({3{tick_slow}} & ~speed_q);

    // pin synchronisers
    logic [5:0] sync1_q, sync2_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {capture_direction_pin, third_count_pin, external_irq_pin_n,
                        second_count_pin, first_count_pin};
            sync2_q <= sync1_q;
        end
    end

    // falling edges seen by two machine-cycle samples, so a count takes two cycles
    logic [3:0] etick, epin, fall;
    assign etick = {tk[2], tk[2], tk[1], tk[0]};
    assign epin = {sync2_q[ttc_pkg::PIN_CAPDIR], sync2_q[ttc_pkg::PIN_T2],
                   sync2_q[ttc_pkg::PIN_T1], sync2_q[ttc_pkg::PIN_T0]};
    for (genvar g = 0; g < 4; g++) begin : g_edge
        logic samp_q;
        always_ff @(posedge clock) begin
            if (!rst_n) samp_q <= 1'b0;
            else if (etick[g]) samp_q <= epin[g];
        end
        assign fall[g] = etick[g] & samp_q & ~epin[g];
    end

    // register bus slave
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q, do_wr;
    logic [31:0] awaddr_q, wdata_q, rdata_q, rd_val;
    logic [3:0] wstrb_q, wsel;
    logic [1:0] bresp_q, rresp_q;
    logic [15:0] we;
    logic wb0, wb1;
    assign axi_rsp.awready = ~aw_have_q & ~bvalid_q;
    assign axi_rsp.wready = ~w_have_q & ~bvalid_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = ~rvalid_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
    assign do_wr = aw_have_q & w_have_q & ~bvalid_q;
    assign wsel = ttc_pkg::ttc_decode(awaddr_q);
    assign we = do_wr ? (16'h1 << wsel) : '0;
    assign wb0 = wstrb_q[0];
    assign wb1 = wstrb_q[1];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (do_wr) aw_have_q <= 1'b0;
        else if (axi_req.awvalid && !aw_have_q && !bvalid_q) begin
            aw_have_q <= 1'b1;
            awaddr_q <= axi_req.awaddr;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (do_wr) w_have_q <= 1'b0;
        else if (axi_req.wvalid && !w_have_q && !bvalid_q) begin
            w_have_q <= 1'b1;
            wdata_q <= axi_req.wdata;
            wstrb_q <= axi_req.wstrb;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= ttc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wsel == ttc_pkg::IDX_NONE) ? ttc_pkg::RESP_SLVERR : ttc_pkg::RESP_OKAY;
        end else if (axi_req.bready) bvalid_q <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= ttc_pkg::RESP_OKAY;
        end else if (axi_req.arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= (ttc_pkg::ttc_decode(axi_req.araddr) == ttc_pkg::IDX_NONE) ?
                       ttc_pkg::RESP_SLVERR : ttc_pkg::RESP_OKAY;
        end else if (axi_req.rready) rvalid_q <= 1'b0;
    end

    // control registers
    ttc_pkg::ttc_timer_control_reg_s timer_control_reg_q;
    ttc_pkg::ttc_timer_mode_reg_s timer_mode_reg_q;
    ttc_pkg::ttc_third_timer_control_reg_s third_timer_control_reg_q;
    ttc_pkg::ttc_third_timer_mode_reg_s third_timer_mode_reg_q;
    logic [7:0] t0_lo_q, t0_hi_q, t1_lo_q, t1_hi_q;
    logic [15:0] t2_cnt_q, cap_q, t2_d;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_mode_reg_q <= '0;
            third_timer_mode_reg_q <= '0;
            speed_q <= '0;
        end else begin
            if (we[ttc_pkg::IDX_TIMER_MODE_REG] && wb0) timer_mode_reg_q <= wdata_q[7:0];
            if (we[ttc_pkg::IDX_THIRD_TIMER_MODE_REG] && wb0) third_timer_mode_reg_q <= wdata_q[1:0];
            if (we[ttc_pkg::IDX_SPEED] && wb0) speed_q <= wdata_q[2:0];
        end
    end

    // one counting step of a timer 0/1 in modes 0-2: {overflow, high, low}
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi,
                                         input logic [7:0] lo);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {1'b0, hi, lo[4:0]} + 14'h1;
        c16 = {1'b0, hi, lo} + 17'h1;
        c8 = {1'b0, lo} + 9'h1;
        case (m)
            ttc_pkg::MODE_13: step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            ttc_pkg::MODE_16: step = c16;
            default: step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
        endcase
    endfunction : step

    // timers 0 and 1
    logic t0m3, t1m3, en0, en1, inc0, inc1, hinc0, ovf0, ovf0h, ovf1;
    logic [16:0] st0, st1;
    assign t0m3 = (timer_mode_reg_q.mode0 == ttc_pkg::MODE_SPLIT);
    assign t1m3 = (timer_mode_reg_q.mode1 == ttc_pkg::MODE_SPLIT);
    assign en0 = timer_control_reg_q.first_timer_run & (~timer_mode_reg_q.gate0 | sync2_q[ttc_pkg::PIN_INT0]);
    assign en1 = timer_control_reg_q.second_timer_run & (~timer_mode_reg_q.gate1 | sync2_q[ttc_pkg::PIN_INT1]);
    assign inc0 = en0 & (timer_mode_reg_q.ct0 ? fall[0] : tk[0]);
    // timer 1 loses its run bit and flag to the split high byte
    assign inc1 = ~t1m3 & (t0m3 ? tk[1] : en1 & (timer_mode_reg_q.ct1 ? fall[1] : tk[1]));
    assign hinc0 = t0m3 & timer_control_reg_q.second_timer_run & tk[0];
    assign st0 = step(timer_mode_reg_q.mode0, t0_hi_q, t0_lo_q);
    assign st1 = step(timer_mode_reg_q.mode1, t1_hi_q, t1_lo_q);
    assign ovf0 = inc0 & (t0m3 ? (t0_lo_q == ttc_pkg::BYTE_TOP) : st0[16]);
    assign ovf0h = hinc0 & (t0_hi_q == ttc_pkg::BYTE_TOP);
    assign ovf1 = inc1 & st1[16] & ~t0m3;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            t0_lo_q <= '0;
            t0_hi_q <= '0;
        end else begin
            if (we[ttc_pkg::IDX_T0] && wb0) t0_lo_q <= wdata_q[7:0];
            else if (inc0) t0_lo_q <= t0m3 ? t0_lo_q + 8'h1 : st0[7:0];
            if (we[ttc_pkg::IDX_T0] && wb1) t0_hi_q <= wdata_q[15:8];
            else if (hinc0) t0_hi_q <= t0_hi_q + 8'h1;
            else if (inc0 && !t0m3) t0_hi_q <= st0[15:8];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            t1_lo_q <= '0;
            t1_hi_q <= '0;
        end else begin
            if (we[ttc_pkg::IDX_T1] && wb0) t1_lo_q <= wdata_q[7:0];
            else if (inc1) t1_lo_q <= st1[7:0];
            if (we[ttc_pkg::IDX_T1] && wb1) t1_hi_q <= wdata_q[15:8];
            else if (inc1) t1_hi_q <= st1[15:8];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) timer_control_reg_q <= '0;
        else begin
            if (we[ttc_pkg::IDX_CTRL] && wb0) timer_control_reg_q <= wdata_q[3:0];
            if (ovf0) timer_control_reg_q.first_timer_overflow <= 1'b1;
            if (ovf1 || ovf0h) timer_control_reg_q.second_timer_overflow <= 1'b1;
        end
    end
    assign first_timer_overflow = timer_control_reg_q.first_timer_overflow;
    assign second_timer_overflow = timer_control_reg_q.second_timer_overflow;

    // timer 2
    logic baud, capm, udm, inc2, exev, dir_up, at_top, at_cap, reload2, cap_ld;
    assign baud = third_timer_control_reg_q.transmit_baud_select | third_timer_control_reg_q.receive_baud_select;
    assign capm = ~baud & third_timer_control_reg_q.capture_reload_select;
    assign udm = ~baud & ~third_timer_control_reg_q.capture_reload_select & third_timer_mode_reg_q.up_down_enable;
    assign inc2 = third_timer_control_reg_q.third_timer_run & (third_timer_control_reg_q.third_source_select ? fall[2] : tk[2]);
    assign exev = third_timer_control_reg_q.external_event_enable & fall[3];
    assign dir_up = sync2_q[ttc_pkg::PIN_CAPDIR];
    assign at_top = (t2_cnt_q == ttc_pkg::CNT_TOP);
    assign at_cap = (t2_cnt_q == cap_q);
    assign reload2 = inc2 & ((udm & ~dir_up) ? at_cap : at_top);
    assign cap_ld = capm & exev;

    always_comb begin
        t2_d = t2_cnt_q;
        if (inc2) begin
            if (udm && !dir_up) t2_d = at_cap ? ttc_pkg::CNT_TOP : t2_cnt_q - 16'h1;
            else if (capm || !at_top) t2_d = t2_cnt_q + 16'h1;
            else t2_d = cap_q;
        end
        // direction pin steers counting in up/down mode, not reloads
        if (exev && !udm && !baud) begin
            if (capm) t2_d = third_timer_mode_reg_q.clear_after_capture ? '0 : t2_d;
            else t2_d = cap_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) t2_cnt_q <= '0;
        else begin
            t2_cnt_q <= t2_d;
            if (we[ttc_pkg::IDX_T2CNT] && wb0) t2_cnt_q[7:0] <= wdata_q[7:0];
            if (we[ttc_pkg::IDX_T2CNT] && wb1) t2_cnt_q[15:8] <= wdata_q[15:8];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) cap_q <= '0;
        else if (cap_ld) cap_q <= t2_cnt_q;
        else begin
            if (we[ttc_pkg::IDX_CAP] && wb0) cap_q[7:0] <= wdata_q[7:0];
            if (we[ttc_pkg::IDX_CAP] && wb1) cap_q[15:8] <= wdata_q[15:8];
        end
    end

    // hardware sets the flags or toggles the external one here; the register write clears them
    always_ff @(posedge clock) begin
        if (!rst_n) third_timer_control_reg_q <= '0;
        else begin
            if (we[ttc_pkg::IDX_THIRD_TIMER_CONTROL_REG] && wb0) third_timer_control_reg_q <= wdata_q[7:0];
            if (reload2 && !baud) third_timer_control_reg_q.third_timer_overflow <= 1'b1;
            if (reload2 && udm) third_timer_control_reg_q.external_event_flag <= ~third_timer_control_reg_q.external_event_flag;
            else if (exev && !udm) third_timer_control_reg_q.external_event_flag <= 1'b1;
        end
    end
    // up/down mode uses the external flag as a toggle, so it is kept off the request
    assign third_timer_irq = third_timer_control_reg_q.third_timer_overflow |
                             (third_timer_control_reg_q.external_event_flag & ~udm);

    always_comb begin
        case (ttc_pkg::ttc_decode(axi_req.araddr))
            ttc_pkg::IDX_CTRL: rd_val = {28'h0, timer_control_reg_q};
            ttc_pkg::IDX_TIMER_MODE_REG: rd_val = {24'h0, timer_mode_reg_q};
            ttc_pkg::IDX_T0: rd_val = {16'h0, t0_hi_q, t0_lo_q};
            ttc_pkg::IDX_T1: rd_val = {16'h0, t1_hi_q, t1_lo_q};
            ttc_pkg::IDX_THIRD_TIMER_CONTROL_REG: rd_val = {24'h0, third_timer_control_reg_q};
            ttc_pkg::IDX_THIRD_TIMER_MODE_REG: rd_val = {30'h0, third_timer_mode_reg_q};
            ttc_pkg::IDX_T2CNT: rd_val = {16'h0, t2_cnt_q};
            ttc_pkg::IDX_CAP: rd_val = {16'h0, cap_q};
            ttc_pkg::IDX_SPEED: rd_val = {29'h0, speed_q};
            default: rd_val = '0;
        endcase
    end

    AST_M2_RELOAD: assert property (
        inc0 && timer_mode_reg_q.mode0 == ttc_pkg::MODE_RELOAD && t0_lo_q == ttc_pkg::BYTE_TOP
        && !we[ttc_pkg::IDX_T0] && !we[ttc_pkg::IDX_CTRL]
        |=> t0_lo_q == $past(t0_hi_q) && timer_control_reg_q.first_timer_overflow)
        else $error("mode 2 reload or flag missing");
    AST_M2_HIGH_KEPT: assert property (
        inc0 && timer_mode_reg_q.mode0 == ttc_pkg::MODE_RELOAD && !we[ttc_pkg::IDX_T0]
        |=> $stable(t0_hi_q))
        else $error("mode 2 changed high byte");
    AST_M0_WRAP: assert property (
        inc0 && timer_mode_reg_q.mode0 == ttc_pkg::MODE_13 && {t0_hi_q, t0_lo_q[4:0]} == ttc_pkg::M0_TOP
        && !we[ttc_pkg::IDX_T0] && !we[ttc_pkg::IDX_CTRL]
        |=> t0_hi_q == '0 && t0_lo_q[4:0] == '0 && $stable(t0_lo_q[7:5])
        && timer_control_reg_q.first_timer_overflow)
        else $error("mode 0 wrap wrong");
    AST_T0_GATED: assert property (
        !t0m3 && !en0 && !we[ttc_pkg::IDX_T0] |=> $stable({t0_hi_q, t0_lo_q}))
        else $error("timer 0 counted while disabled");
    AST_T1_FROZEN: assert property (
        t1m3 && !we[ttc_pkg::IDX_T1] |=> $stable({t1_hi_q, t1_lo_q}))
        else $error("timer 1 moved in mode 3");
    AST_T2_CAPTURE: assert property (
        capm && exev && !we[ttc_pkg::IDX_THIRD_TIMER_CONTROL_REG]
        |=> cap_q == $past(t2_cnt_q) && third_timer_control_reg_q.external_event_flag)
        else $error("capture missed");
    AST_T2_CLEAR: assert property (
        capm && exev && third_timer_mode_reg_q.clear_after_capture && !we[ttc_pkg::IDX_T2CNT]
        |=> t2_cnt_q == '0)
        else $error("count not cleared after capture");
    AST_BAUD_NOFLAG: assert property (
        baud && inc2 && at_top && !we[ttc_pkg::IDX_T2CNT] && !we[ttc_pkg::IDX_THIRD_TIMER_CONTROL_REG]
        |=> t2_cnt_q == $past(cap_q) && $stable(third_timer_control_reg_q.third_timer_overflow))
        else $error("baud reload wrong");
    AST_DOWN_RELOAD: assert property (
        udm && inc2 && !dir_up && at_cap && !we[ttc_pkg::IDX_T2CNT] && !we[ttc_pkg::IDX_THIRD_TIMER_CONTROL_REG]
        |=> t2_cnt_q == ttc_pkg::CNT_TOP && third_timer_control_reg_q.third_timer_overflow
        && third_timer_control_reg_q.external_event_flag != $past(third_timer_control_reg_q.external_event_flag))
        else $error("down reload wrong");
    AST_UD_NO_IRQ: assert property (
        udm && !third_timer_control_reg_q.third_timer_overflow |-> !third_timer_irq)
        else $error("external flag raised irq in up/down mode");
endmodule : ttc_top

// *** dv/ttc_pin_model.sv ***
/* pin-side partner: count, gate and capture/direction pins of the timers.
   assumes the bench calls its tasks from a clocked sequence; pins idle high. */
`timescale 1ns/10ps
module ttc_pin_model (
    input wire logic clock,
    output logic first_count_pin,
    output logic second_count_pin,
    output logic third_count_pin,
    output logic [1:0] external_irq_pin_n,
    output logic capture_direction_pin
);
    initial begin
        first_count_pin = 1'b1;
        second_count_pin = 1'b1;
        third_count_pin = 1'b1;
        external_irq_pin_n = 2'h3;
        capture_direction_pin = 1'b1;
    end
    // each level held past two slow machine cycles so one sample sees it
    task automatic pulse_second();
        second_count_pin <= 1'b0;
        repeat (30) @(posedge clock);
        second_count_pin <= 1'b1;
        repeat (30) @(posedge clock);
    endtask : pulse_second
    task automatic set_dir(input logic v);
        capture_direction_pin <= v;
        repeat (30) @(posedge clock);
    endtask : set_dir
    task automatic fall_cap();
        set_dir(1'b1);
        set_dir(1'b0);
    endtask : fall_cap
endmodule : ttc_pin_model

// *** dv/three_timer_counter_unit_test.sv ***
/* self-checking bench of the three timer/counter unit over AXI4-Lite.
   assumes ttc_top and ttc_pin_model; flags cleared by software writes. */
`timescale 1ns/10ps
module three_timer_counter_unit_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    ttc_pkg::ttc_axi_req_s req = '0;
    ttc_pkg::ttc_axi_rsp_s rsp;
    logic p0, p1, p2, cdir, ovf0, ovf1, irq2;
    logic [1:0] irq_n;
    logic [1:0] resp;
    logic [31:0] rd = '0;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    always #2.5 clock = ~clock;
    ttc_top i_ttc_top (.clock(clock), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
        .first_count_pin(p0), .second_count_pin(p1), .third_count_pin(p2),
        .external_irq_pin_n(irq_n), .capture_direction_pin(cdir),
        .first_timer_overflow(ovf0), .second_timer_overflow(ovf1), .third_timer_irq(irq2));
    ttc_pin_model i_ttc_pin_model (.clock(clock), .first_count_pin(p0),
        .second_count_pin(p1), .third_count_pin(p2), .external_irq_pin_n(irq_n),
        .capture_direction_pin(cdir));
    task automatic results();
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // a hang is cut short well past the roughly nine hundred cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        @(posedge clock);
    endtask : wr
    task automatic rd_reg(input logic [31:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                rd = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        @(posedge clock);
    endtask : rd_reg
    task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        rd_reg(a);
        chk(rd & m, e);
    endtask : rchk
    // bounded poll; a flag that never rises shows up in the following compare
    task automatic poll(input logic [31:0] a, input int b);
        rd_reg(a);
        for (int i = 0; i < 400 && !rd[b]; i++) rd_reg(a);
    endtask : poll
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rchk(32'h00, 32'hffffffff, 32'h0);
        rd_reg(32'h24);
        chk({30'h0, resp}, 32'h2);
        wr(32'h24, 32'h1);
        chk({30'h0, resp}, 32'h2);
        wr(32'h08, 32'ha5fe);
        wr(32'h0c, 32'h0);
        wr(32'h04, 32'h52);
        wr(32'h20, 32'h5);
        wr(32'h00, 32'h3);
        repeat (3) i_ttc_pin_model.pulse_second();
        poll(32'h00, 2);
        chk({31'h0, ovf0}, 32'h1);
        rchk(32'h08, 32'hff00, 32'ha500);
        rchk(32'h0c, 32'hffff, 32'h3);
        wr(32'h00, 32'h0);
        wr(32'h04, 32'h0);
        wr(32'h0c, 32'hffff);
        wr(32'h00, 32'h2);
        poll(32'h00, 3);
        chk({31'h0, ovf1}, 32'h1);
        wr(32'h00, 32'h0);
        rchk(32'h0c, 32'hffe0, 32'he0);
        wr(32'h08, 32'hfe00);
        wr(32'h0c, 32'h1234);
        wr(32'h04, 32'h33);
        wr(32'h00, 32'h2);
        poll(32'h00, 3);
        chk({31'h0, ovf1}, 32'h1);
        rchk(32'h08, 32'hff, 32'h0);
        rchk(32'h0c, 32'hffff, 32'h1234);
        wr(32'h00, 32'h0);
        wr(32'h14, 32'h2);
        wr(32'h18, 32'h0100);
        wr(32'h10, 32'h0d);
        i_ttc_pin_model.fall_cap();
        rchk(32'h1c, 32'hff00, 32'h0100);
        rchk(32'h10, 32'h40, 32'h40);
        chk({31'h0, irq2}, 32'h1);
        rchk(32'h18, 32'hff00, 32'h0);
        wr(32'h10, 32'h0);
        chk({31'h0, irq2}, 32'h0);
        wr(32'h14, 32'h1);
        wr(32'h1c, 32'h0010);
        wr(32'h18, 32'h0014);
        i_ttc_pin_model.set_dir(1'b0);
        wr(32'h10, 32'h04);
        poll(32'h10, 7);
        chk(rd & 32'hc0, 32'hc0);
        wr(32'h10, 32'h40);
        rchk(32'h18, 32'hff00, 32'hff00);
        rchk(32'h10, 32'hc0, 32'h40);
        chk({31'h0, irq2}, 32'h0);
        i_ttc_pin_model.set_dir(1'b1);
        wr(32'h14, 32'h0);
        wr(32'h1c, 32'h1234);
        wr(32'h18, 32'hfff0);
        wr(32'h10, 32'h0c);
        poll(32'h10, 7);
        rchk(32'h18, 32'hff00, 32'h1200);
        i_ttc_pin_model.fall_cap();
        rchk(32'h10, 32'h40, 32'h40);
        rchk(32'h18, 32'hff00, 32'h1200);
        wr(32'h10, 32'h0);
        wr(32'h18, 32'hfff0);
        wr(32'h10, 32'h1d);
        repeat (150) @(posedge clock);
        rchk(32'h10, 32'h80, 32'h0);
        rchk(32'h18, 32'hff00, 32'h1200);
        i_ttc_pin_model.fall_cap();
        rchk(32'h10, 32'hc0, 32'h40);
        chk({31'h0, irq2}, 32'h1);
        results();
    end
endmodule : three_timer_counter_unit_test
